//--- bench/b2s_ctrl_model.sv
// Controller model: clock pair, commands, write data
`timescale 1ns/10ps
module b2s_ctrl_model (
	input wire logic sys_clk,
	input wire logic [17:0] dq_out,
	input wire logic dq_oe,
	output logic k_clk,
	output logic k_clk_n,
	output logic load_strobe_n,
	output logic rw_sel,
	output logic [19:0] addr,
	output logic [1:0] byte_write_select_n,
	output logic [17:0] dq_in
);
	initial begin
		{k_clk, k_clk_n, load_strobe_n} = 3'h1;
		{rw_sel, addr, byte_write_select_n, dq_in} = 41'h0;
	end
	////////////////////////////////
	// One pair period; words belong to the previous load
	task automatic kper(input logic ldn, rw, input logic [19:0] a,
		input logic [17:0] d0, d1, input logic [1:0] b,
		output logic [17:0] q0, q1, output logic oe0, oe1);
		k_clk <= 1'b1;
		k_clk_n <= 1'b0;
		load_strobe_n <= ldn;
		rw_sel <= rw;
		addr <= a;
		dq_in <= d0;
		byte_write_select_n <= b;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		q0 = dq_out;
		oe0 = dq_oe;
		@(posedge sys_clk);
		load_strobe_n <= 1'b0;
		rw_sel <= ~rw;
		addr <= ~a;
		k_clk <= 1'b0;
		k_clk_n <= 1'b1;
		dq_in <= d1;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		q1 = dq_out;
		oe1 = dq_oe;
		@(posedge sys_clk);
	endtask
endmodule

//--- bench/tb.sv
// Bench with core memory and reference model
`timescale 1ns/10ps
module tb;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic k_clk, k_clk_n, load_n, rw_sel, dq_oe, rd_en, wr_en, oe0, oe1, ldn, rw, pl, pr;
	logic [19:0] addr, rd_addr, wr_addr, a, pa;
	logic [1:0] lane_sel_n, lane_en, b;
	logic [17:0] dq_in, dq_out, rd_data, wr_data, q0, q1, d0, d1;
	logic [17:0] mem [0:31];
	logic [17:0] ref_m [0:31];
	b2s_pkg::b2s_beat_t rd_beat, wr_beat;
	int fail_count = 0;
	int checked = 0;
	integer seed = 32'hC1335A89;
	always #25 sys_clk = ~sys_clk;
	////////////////////////////////
	b2s_port u_b2s_port (.sys_clk(sys_clk), .nrst(nrst), .k_clk(k_clk), .k_clk_n(k_clk_n),
		.load_strobe_n(load_n), .rw_sel(rw_sel), .addr(addr), .byte_write_select_n(lane_sel_n),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .core_rd_en(rd_en),
		.core_rd_addr(rd_addr), .core_rd_beat(rd_beat), .core_rd_data(rd_data),
		.core_wr_en(wr_en), .core_wr_addr(wr_addr), .core_wr_beat(wr_beat),
		.core_wr_data(wr_data), .core_wr_lane_en(lane_en));
	b2s_ctrl_model u_b2s_ctrl_model (.sys_clk(sys_clk), .dq_out(dq_out), .dq_oe(dq_oe),
		.k_clk(k_clk), .k_clk_n(k_clk_n), .load_strobe_n(load_n), .rw_sel(rw_sel),
		.addr(addr), .byte_write_select_n(lane_sel_n), .dq_in(dq_in));
	// Core gives garbage outside a read beat
	assign rd_data = rd_en ? mem[{rd_addr[3:0], rd_beat}] : ~mem[{rd_addr[3:0], rd_beat}];
	always @(posedge sys_clk) begin
		for (int i = 0; i < 2; i++) begin
			if (wr_en && lane_en[i]) begin
				mem[{wr_addr[3:0], wr_beat}][i*9+:9] <= wr_data[i*9+:9];
			end
		end
	end
	////////////////////////////////
	task automatic check(input string what, input logic [17:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		final_report();
	end
	initial begin
		for (int i = 0; i < 32; i++) begin
			mem[i] = 18'h0;
			ref_m[i] = 18'h0;
		end
		{pl, pr, pa} = {2'h2, 20'h0};
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		for (int n = 0; n < 300; n++) begin
			ldn = n == 299 || ($random(seed) & 3) == 0;
			rw = 1'($random(seed));
			a = {16'h0, 4'($random(seed))};
			d0 = 18'($random(seed));
			d1 = 18'($random(seed));
			b = 2'($random(seed));
			u_b2s_ctrl_model.kper(ldn, rw, a, d0, d1, b, q0, q1, oe0, oe1);
			// drivers only for a read burst
			check("oe0", {17'h0, oe0}, {17'h0, !pl && pr});
			check("oe1", {17'h0, oe1}, {17'h0, !pl && pr});
			if (!pl && pr) begin
				check("q0", q0, ref_m[{pa[3:0], 1'b0}]);
				check("q1", q1, ref_m[{pa[3:0], 1'b1}]);
			end
			for (int i = 0; i < 2; i++) begin
				if (!pl && !pr && !b[i]) begin
					ref_m[{pa[3:0], 1'b0}][i*9+:9] = d0[i*9+:9];
					ref_m[{pa[3:0], 1'b1}][i*9+:9] = d1[i*9+:9];
				end
			end
			{pl, pr, pa} = {ldn, rw, a};
		end
		final_report();
	end
endmodule

//--- hdl/b2s_map.svh
// Widths and lane layout of the burst-of-two data and load port
`ifndef B2S_MAP_SVH
`define B2S_MAP_SVH
`define B2S_DATA_W_NARROW 18
`define B2S_DATA_W_WIDE 36
`define B2S_LANE_W 9
`define B2S_ADDR_W 20
`define B2S_BURST_LEN 2
`endif

//--- hdl/b2s_pkg.sv
// Types shared by the burst-of-two port
package b2s_pkg;
	typedef enum logic [0:0] {
		B2S_BEAT_FIRST = 1'b0,
		B2S_BEAT_SECOND = 1'b1
	} b2s_beat_t;
endpackage

//--- hdl/b2s_port.sv
// Device-side data, load and byte-select port of a burst-of-two DDR memory
`timescale 1ns/10ps
`include "b2s_map.svh"

// What this block does
// - Write data sampled on both clock rises
// - Read data driven on both clock rises
// - Data drivers off unless read selected
// - Read returns core data, 18 or 36 bits
// - Load strobe sampled on true rise only
// - Each operation moves exactly two words
// - Select high reads, low writes
// - Address sampled on true clock rise
// - Byte selects gate 9-bit lanes with data
module b2s_port #(
	parameter int DATA_W = `B2S_DATA_W_NARROW,
	parameter int ADDR_W = `B2S_ADDR_W,
	parameter int LANES = DATA_W / `B2S_LANE_W
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic k_clk,
	input wire logic k_clk_n,
	input wire logic load_strobe_n,
	input wire logic rw_sel,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [LANES-1:0] byte_write_select_n,
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe,
	output logic core_rd_en,
	output logic [ADDR_W-1:0] core_rd_addr,
	output b2s_pkg::b2s_beat_t core_rd_beat,
	input wire logic [DATA_W-1:0] core_rd_data,
	output logic core_wr_en,
	output logic [ADDR_W-1:0] core_wr_addr,
	output b2s_pkg::b2s_beat_t core_wr_beat,
	output logic [DATA_W-1:0] core_wr_data,
	output logic [LANES-1:0] core_wr_lane_en
);

	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic k_q;
		logic kn_q;
		logic pend_v;
		logic pend_rd;
		logic [ADDR_W-1:0] pend_addr;
		logic cur_v;
		logic cur_rd;
		logic [ADDR_W-1:0] cur_addr;
		logic [DATA_W-1:0] dq_out;
		logic dq_oe;
		logic wr_en;
		logic [ADDR_W-1:0] wr_addr;
		b2s_pkg::b2s_beat_t wr_beat;
		logic [DATA_W-1:0] wr_data;
		logic [LANES-1:0] wr_lane;
	} b2s_state_t;

	b2s_state_t st_r;
	b2s_state_t st_nxt;
	logic k_rise;
	logic kn_rise;

	// Both clocks arrive as plain sampled levels, so edges are found here
	assign k_rise = k_clk & ~st_r.k_q;
	assign kn_rise = k_clk_n & ~st_r.kn_q;

	// Core read is asynchronous so the word lands in the output flop on the edge
	assign core_rd_en = (k_rise & st_r.pend_v & st_r.pend_rd) |
		(kn_rise & st_r.cur_v & st_r.cur_rd);
	assign core_rd_addr = k_rise ? st_r.pend_addr : st_r.cur_addr;
	assign core_rd_beat = k_rise ? b2s_pkg::B2S_BEAT_FIRST : b2s_pkg::B2S_BEAT_SECOND;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		st_nxt.k_q = k_clk;
		st_nxt.kn_q = k_clk_n;
		st_nxt.wr_en = 1'b0;
		if (k_rise) begin
			// Loaded operation becomes a two-beat burst
			st_nxt.cur_v = st_r.pend_v;
			st_nxt.cur_rd = st_r.pend_rd;
			st_nxt.cur_addr = st_r.pend_addr;
			// Load, direction and address on true rise
			st_nxt.pend_v = ~load_strobe_n;
			st_nxt.pend_rd = rw_sel;
			st_nxt.pend_addr = addr;
			if (st_r.pend_v && !st_r.pend_rd) begin
				st_nxt.wr_en = 1'b1;
				st_nxt.wr_addr = st_r.pend_addr;
				st_nxt.wr_beat = b2s_pkg::B2S_BEAT_FIRST;
				st_nxt.wr_data = dq_in;
				st_nxt.wr_lane = ~byte_write_select_n;
			end
			if (st_r.pend_v && st_r.pend_rd) begin
				st_nxt.dq_out = core_rd_data;
				st_nxt.dq_oe = 1'b1;
			end else begin
				st_nxt.dq_oe = 1'b0;
			end
		end else if (kn_rise) begin
			st_nxt.cur_v = 1'b0;
			if (st_r.cur_v && !st_r.cur_rd) begin
				st_nxt.wr_en = 1'b1;
				st_nxt.wr_addr = st_r.cur_addr;
				st_nxt.wr_beat = b2s_pkg::B2S_BEAT_SECOND;
				st_nxt.wr_data = dq_in;
				st_nxt.wr_lane = ~byte_write_select_n;
			end
			if (st_r.cur_v && st_r.cur_rd) begin
				st_nxt.dq_out = core_rd_data;
				st_nxt.dq_oe = 1'b1;
			end else begin
				st_nxt.dq_oe = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dq_out = st_r.dq_out;
	assign dq_oe = st_r.dq_oe;
	assign core_wr_en = st_r.wr_en;
	assign core_wr_addr = st_r.wr_addr;
	assign core_wr_beat = st_r.wr_beat;
	assign core_wr_data = st_r.wr_data;
	assign core_wr_lane_en = st_r.wr_lane;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	sequence s_first_beat;
		k_rise && st_r.pend_v;
	endsequence

	// Both clocks rising together: only the true rise acts
	sequence s_second_beat;
		!k_rise && kn_rise && st_r.cur_v;
	endsequence

	property p_wr_first;
		s_first_beat ##0 !st_r.pend_rd |=> core_wr_en &&
			core_wr_beat == b2s_pkg::B2S_BEAT_FIRST && core_wr_data == $past(dq_in) &&
			core_wr_addr == $past(st_r.pend_addr);
	endproperty
	a_wr_first: assert property (p_wr_first) else $error("write beat one lost");

	property p_wr_second;
		s_second_beat ##0 !st_r.cur_rd |=> core_wr_en &&
			core_wr_beat == b2s_pkg::B2S_BEAT_SECOND && core_wr_data == $past(dq_in) &&
			core_wr_addr == $past(st_r.cur_addr) &&
			core_wr_lane_en == ~$past(byte_write_select_n);
	endproperty
	a_wr_second: assert property (p_wr_second) else $error("write beat two lost");

	property p_rd_first;
		s_first_beat ##0 st_r.pend_rd |=> dq_oe && dq_out == $past(core_rd_data);
	endproperty
	a_rd_first: assert property (p_rd_first) else $error("read beat one wrong");

	property p_rd_second;
		s_second_beat ##0 st_r.cur_rd |=> dq_oe && dq_out == $past(core_rd_data);
	endproperty
	a_rd_second: assert property (p_rd_second) else $error("read beat two wrong");

	property p_hiz;
		(k_rise && !(st_r.pend_v && st_r.pend_rd)) or
			(!k_rise && kn_rise && !(st_r.cur_v && st_r.cur_rd)) |=> !dq_oe;
	endproperty
	a_hiz: assert property (p_hiz) else $error("bus driven without read");

	property p_load_true_only;
		!k_rise |=> st_r.pend_v == $past(st_r.pend_v) &&
			st_r.pend_addr == $past(st_r.pend_addr);
	endproperty
	a_load_true_only: assert property (p_load_true_only) else $error("load off true rise");

	property p_burst;
		s_first_beat |=> st_r.cur_v && st_r.cur_addr == $past(st_r.pend_addr);
	endproperty
	a_burst: assert property (p_burst) else $error("second beat not armed");

	property p_dir;
		k_rise && !load_strobe_n |=> st_r.pend_v && st_r.pend_rd == $past(rw_sel);
	endproperty
	a_dir: assert property (p_dir) else $error("direction not loaded");

	property p_addr;
		k_rise && !load_strobe_n |=> st_r.pend_addr == $past(addr);
	endproperty
	a_addr: assert property (p_addr) else $error("address not loaded");

	property p_lanes;
		s_first_beat ##0 !st_r.pend_rd |=> core_wr_lane_en == ~$past(byte_write_select_n);
	endproperty
	a_lanes: assert property (p_lanes) else $error("lane enables wrong");

endmodule
